/* File: adc_ctrl_regs.svh */
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ADDR_RESULT_LOW   12'h000
`define ADDR_RESULT_HIGH  12'h004
`define ADDR_CONTROL_A    12'h008
`define ADDR_CONTROL_B    12'h00c

// ----------------------------------------------------------------------------
// Control A fields
// ----------------------------------------------------------------------------
`define CA_START_BIT      7
`define CA_BUSY_BIT       6
`define CA_ENABLE_BIT     5
`define CA_JUSTIFY_BIT    4
`define CA_CHAN_MSB       3
`define CA_CHAN_LSB       0
`define CA_RESET          8'h00

// ----------------------------------------------------------------------------
// Control B fields
// ----------------------------------------------------------------------------
`define CB_SRC_MSB        7
`define CB_SRC_LSB        5
`define CB_REF_MSB        4
`define CB_REF_LSB        3
`define CB_DIV_MSB        2
`define CB_DIV_LSB        0
`define CB_RESET          8'h00

// ----------------------------------------------------------------------------
// Source and channel codes
// ----------------------------------------------------------------------------
`define SRC_OVERCURRENT   3'h1
`define SRC_DCDC          3'h2
`define CHAN_LAST_PIN     4'h5
`define NUM_PINS          6
`define REF_SUPPLY        2'h1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CONV_TICKS_DEFAULT 16

`endif

/* File: adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

    // Analog input routing choice
    typedef enum logic [1:0] {
        ROUTE_PIN,
        ROUTE_OVERCURRENT,
        ROUTE_DCDC,
        ROUTE_FLOAT
    } route_e;

    // Conversion sequencer state
    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_ARMED,
        CONV_RUN
    } conv_state_e;

    // Sample of the analog core's 12-bit answer
    typedef logic [11:0] sample_t;

endpackage

/* File: adc_clock_divider.sv */
`timescale 1ns/10ps
`default_nettype none

// Produces one-cycle conversion clock ticks at clk divided by 2**code.
module adc_clock_divider (
    // System
    input  wire logic       clk,
    input  wire logic       reset,
    // Control
    input  wire logic       run,
    input  wire logic [2:0] div_code,
    // Output
    output logic            tick
);
    import adc_ctrl_pkg::*;

    typedef struct packed {
        logic [6:0] count;    // Free counter within one period
    } div_s;

    div_s state_q;            // Registered state
    div_s state_d;            // Next state
    logic [6:0] period_mask;  // All-ones of width div_code

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        state_d     = state_q;
        period_mask = 7'((8'h01 << div_code) - 8'h01);
        // Counter held at zero outside a conversion so the first tick lands
        // a full period after start, whatever the code.
        if (!run) begin
            state_d.count = 7'h00;
        end else if ((state_q.count & period_mask) == period_mask) begin
            state_d.count = 7'h00;
        end else begin
            state_d.count = state_q.count + 7'h01;
        end
    end

    assign tick = run && ((state_q.count & period_mask) == period_mask); // RL15

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // At divider code 1, a tick is never followed by another tick in the next cycle
    AST_TICK_SPACING: assert property (@(posedge clk) disable iff (reset)
        (tick && run && $stable(div_code) && div_code == 3'h1) |=> !tick) // RL15
        else $error("Divide-by-two tick repeated back to back");

endmodule

`default_nettype wire

/* File: adc_control.sv */
//
// Overview of operation
// RL1 - Every conversion yields a twelve-bit result
// RL2 - Result held in read-only high/low bytes
// RL3 - Justify bit picks left or right alignment
// RL4 - Unused result bit positions read zero
// RL5 - Disabled converter clears both result bytes
// RL6 - Source codes 000,011-111 select external pin
// RL7 - Source 001 routes overcurrent amplifier output
// RL8 - Source 010 routes divided DC/DC voltage
// RL9 - Channel 0-5 select pins; others float
// RL10 - Software floats channel when internal source
// RL11 - Software configures pin sharing for internal
// RL12 - Two eight-bit control registers, fixed layout
// RL13 - Start rise resets, start fall begins
// RL14 - Busy during conversion; completion raises request
// RL15 - Divider code selects clock divide 1..128
// RL16 - Reference: 01 supply, otherwise reference pin
// RL17 - Both result bytes update together; length parameter
// RL18 - Busy write ignored; others read back
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_regs.svh"

module adc_control #(
    parameter int CONV_TICKS = `CONV_TICKS_DEFAULT
) (
    // System
    input  wire logic                 clk,
    input  wire logic                 reset,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // Analog core
    input  wire adc_ctrl_pkg::sample_t core_result,
    output logic                      core_reset,
    output logic                      core_sample,
    output logic                      core_power,
    output logic                      core_clock_tick,
    output logic [`NUM_PINS-1:0]      analog_pin_inputs_sel,
    output logic                      overcurrent_amp_output_sel,
    output logic                      dcdc_divider_sel,
    output logic                      reference_from_supply,
    // Interrupt request flag to the system interrupt controller
    output logic                      conversion_done
);
    import adc_ctrl_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  control_a;     // Start, enable, justify, channel
        logic [7:0]  control_b;     // Source, reference, divider
        logic        busy;          // Conversion in progress
        conv_state_e conv;          // Sequencer state
        logic [15:0] ticks;         // Divided clocks elapsed
        sample_t     result;        // Latched twelve-bit result
        logic        done;          // One-cycle completion pulse
        logic [31:0] rdata;         // Registered read data
        logic        core_rst;      // Core reset pulse
        logic        core_smp;      // Core sample pulse
    } ctrl_s;

    ctrl_s state_q;                 // Registered state
    ctrl_s state_d;                 // Next state

    logic       wr_access;          // APB write in access phase
    logic       rd_access;          // APB read in setup phase
    logic       start_new;          // Start bit to be written
    logic       div_tick;           // Conversion clock tick
    route_e     route;              // Decoded analog route
    logic [7:0] high_byte;          // Formatted high byte
    logic [7:0] low_byte;           // Formatted low byte

    // ------------------------------------------------------------------------
    // Input routing decode, used for the overcurrent and DC/DC select outputs
    // ------------------------------------------------------------------------
    function automatic route_e decode_route(input logic [2:0] src, input logic [3:0] chan);
        route_e r;
        r = ROUTE_FLOAT;
        if (src == `SRC_OVERCURRENT) begin
            r = ROUTE_OVERCURRENT;                             // RL7
        end else if (src == `SRC_DCDC) begin
            r = ROUTE_DCDC;                                    // RL8
        end else if (chan <= `CHAN_LAST_PIN) begin
            r = ROUTE_PIN;                                     // RL6
        end
        return r;
    endfunction

    assign route = decode_route(state_q.control_b[`CB_SRC_MSB:`CB_SRC_LSB],
                                state_q.control_a[`CA_CHAN_MSB:`CA_CHAN_LSB]);

    // Pin switches close only for a pin route. An internal source keeps every pin
    // open whatever the channel code, without help from software.
    generate
        for (genvar i = 0; i < `NUM_PINS; i++) begin : g_pin
            assign analog_pin_inputs_sel[i] =
                (state_q.control_b[`CB_SRC_MSB:`CB_SRC_LSB] != `SRC_OVERCURRENT) &&
                (state_q.control_b[`CB_SRC_MSB:`CB_SRC_LSB] != `SRC_DCDC) &&
                (state_q.control_a[`CA_CHAN_MSB:`CA_CHAN_LSB] == 4'(i));  // RL9
        end
    endgenerate

    assign overcurrent_amp_output_sel = (route == ROUTE_OVERCURRENT);
    assign dcdc_divider_sel           = (route == ROUTE_DCDC);
    // Reference pin for 00 and 1x; only 01 picks the supply
    assign reference_from_supply =
        (state_q.control_b[`CB_REF_MSB:`CB_REF_LSB] == `REF_SUPPLY);  // RL16

    // ------------------------------------------------------------------------
    // Result formatting
    // ------------------------------------------------------------------------
    always_comb begin
        if (state_q.control_a[`CA_JUSTIFY_BIT]) begin
            high_byte = {4'h0, state_q.result[11:8]};          // RL3 RL4
            low_byte  = state_q.result[7:0];                   // RL3
        end else begin
            high_byte = state_q.result[11:4];                  // RL3
            low_byte  = {state_q.result[3:0], 4'h0};           // RL3 RL4
        end
    end

    // ------------------------------------------------------------------------
    // Conversion clock divider
    // ------------------------------------------------------------------------
    adc_clock_divider u_div (
        .clk      (clk),
        .reset    (reset),
        .run      (state_q.conv == CONV_RUN),
        .div_code (state_q.control_b[`CB_DIV_MSB:`CB_DIV_LSB]),
        .tick     (div_tick)
    );

    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && !penable && !pwrite;
    assign start_new = pwdata[`CA_START_BIT];

    // ------------------------------------------------------------------------
    // Next state: registers, start handshake, sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        state_d          = state_q;
        state_d.done     = 1'b0;
        state_d.core_rst = 1'b0;
        state_d.core_smp = 1'b0;

        // Sequencer counts divided clocks; a parameter sets the length
        if (state_q.conv == CONV_RUN && div_tick) begin
            if (state_q.ticks == 16'(CONV_TICKS - 1)) begin
                state_d.conv   = CONV_IDLE;
                state_d.busy   = 1'b0;                         // RL14
                state_d.done   = 1'b1;                         // RL14
                state_d.result = core_result;                  // RL1 RL17
                state_d.ticks  = 16'h0000;
            end else begin
                state_d.ticks = state_q.ticks + 16'h0001;
            end
        end

        // Register writes take effect at the access edge
        if (wr_access) begin
            if (paddr == `ADDR_CONTROL_A) begin
                // Busy is hardware-owned; its written value is dropped
                state_d.control_a = {pwdata[7], state_q.control_a[6], pwdata[5:0]};  // RL12 RL18
                if (start_new && !state_q.control_a[`CA_START_BIT]) begin
                    // Rising start: reset core, abandon any conversion
                    state_d.conv     = CONV_ARMED;
                    state_d.busy     = 1'b0;                   // RL13
                    state_d.core_rst = 1'b1;                   // RL13
                    state_d.ticks    = 16'h0000;
                    state_d.done     = 1'b0;
                end else if (!start_new && state_q.control_a[`CA_START_BIT] &&
                             state_q.conv == CONV_ARMED && pwdata[`CA_ENABLE_BIT]) begin
                    // Falling start after a rise: conversion begins
                    state_d.conv     = CONV_RUN;
                    state_d.busy     = 1'b1;                   // RL13 RL14
                    state_d.core_smp = 1'b1;                   // RL13
                    state_d.ticks    = 16'h0000;
                end
            end else if (paddr == `ADDR_CONTROL_B) begin
                state_d.control_b = pwdata[7:0];               // RL12 RL18
            end
        end

        // Disabled converter: results cleared, conversion dropped
        if (!state_d.control_a[`CA_ENABLE_BIT]) begin
            state_d.result = 12'h000;                          // RL5
            state_d.conv   = CONV_IDLE;
            state_d.busy   = 1'b0;
        end

        // Busy mirrors into its register position for readback
        state_d.control_a[`CA_BUSY_BIT] = state_d.busy;

        // Read data sampled in setup so it stands at the access edge
        if (rd_access) begin
            if (paddr == `ADDR_RESULT_LOW) begin
                state_d.rdata = {24'h000000, low_byte};        // RL2
            end else if (paddr == `ADDR_RESULT_HIGH) begin
                state_d.rdata = {24'h000000, high_byte};       // RL2
            end else if (paddr == `ADDR_CONTROL_A) begin
                state_d.rdata = {24'h000000, state_q.control_a};
            end else if (paddr == `ADDR_CONTROL_B) begin
                state_d.rdata = {24'h000000, state_q.control_b};
            end else begin
                state_d.rdata = 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q           <= '0;
            state_q.control_a <= `CA_RESET;
            state_q.control_b <= `CB_RESET;
            state_q.conv      <= CONV_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Zero-wait slave; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable &&
                     (paddr != `ADDR_RESULT_LOW) && (paddr != `ADDR_RESULT_HIGH) &&
                     (paddr != `ADDR_CONTROL_A) && (paddr != `ADDR_CONTROL_B);
    assign prdata          = state_q.rdata;
    assign core_reset      = state_q.core_rst;
    assign core_sample     = state_q.core_smp;
    assign core_power      = state_q.control_a[`CA_ENABLE_BIT];
    assign core_clock_tick = div_tick;
    assign conversion_done = state_q.done;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    AST_DISABLE_CLEARS: assert property (@(posedge clk) disable iff (reset)
        !state_q.control_a[`CA_ENABLE_BIT] |-> state_q.result == 12'h000) // RL5
        else $error("Result not cleared while disabled");

    AST_LEFT_LOW_ZERO: assert property (@(posedge clk) disable iff (reset)
        !state_q.control_a[`CA_JUSTIFY_BIT] |-> low_byte[3:0] == 4'h0) // RL4
        else $error("Left-justified low nibble not zero");

    AST_RIGHT_HIGH: assert property (@(posedge clk) disable iff (reset)
        state_q.control_a[`CA_JUSTIFY_BIT] |-> high_byte == {4'h0, state_q.result[11:8]}) // RL3
        else $error("Right-justified high byte wrong");

    AST_DONE_CLEARS_BUSY: assert property (@(posedge clk) disable iff (reset)
        conversion_done |-> !state_q.busy && $past(state_q.busy)) // RL14
        else $error("Completion without busy falling");

    AST_FALL_STARTS: assert property (@(posedge clk) disable iff (reset)
        (wr_access && paddr == `ADDR_CONTROL_A && !start_new && state_q.control_a[`CA_START_BIT]
         && state_q.conv == CONV_ARMED && pwdata[`CA_ENABLE_BIT]) |=> state_q.busy && core_sample) // RL13
        else $error("Start fall did not begin conversion");

    AST_RISE_RESETS: assert property (@(posedge clk) disable iff (reset)
        (wr_access && paddr == `ADDR_CONTROL_A && start_new && !state_q.control_a[`CA_START_BIT])
        |=> !state_q.busy && core_reset) // RL13
        else $error("Start rise did not reset converter");

    AST_BUSY_WRITE_IGNORED: assert property (@(posedge clk) disable iff (reset)
        (wr_access && paddr == `ADDR_CONTROL_A && pwdata[`CA_BUSY_BIT] && state_q.conv == CONV_IDLE
         && !start_new) |=> !state_q.busy) // RL18
        else $error("Busy bit took a software write");

    AST_ONE_PIN: assert property (@(posedge clk) disable iff (reset)
        $onehot0(analog_pin_inputs_sel) && !(overcurrent_amp_output_sel && |analog_pin_inputs_sel)) // RL9
        else $error("Analog pin routing overlaps");

    AST_INTERNAL_NO_PIN: assert property (@(posedge clk) disable iff (reset)
        (state_q.control_b[`CB_SRC_MSB:`CB_SRC_LSB] == `SRC_DCDC) |-> analog_pin_inputs_sel == '0) // RL8
        else $error("Pin closed with internal source");

    AST_RESULT_ATOMIC: assert property (@(posedge clk) disable iff (reset)
        (state_q.control_a[`CA_ENABLE_BIT] && !conversion_done && state_q.busy) |-> $stable(state_q.result)) // RL17
        else $error("Result changed mid-conversion");

endmodule

`default_nettype wire

/* File: adc_control_result_format_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_regs.svh"

module adc_control_result_format_tb;
    import adc_ctrl_pkg::*;

    // --------------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------------
    localparam int CT = 2;                  // Short conversion length keeps the run brief
    logic                 clk = 1'b0;
    logic                 reset = 1'b1;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [11:0]          paddr = 12'h000;
    logic [31:0]          pwdata = 32'h0;
    logic                 pready;
    logic [31:0]          prdata;
    logic                 pslverr;
    sample_t              core_result = 12'h000;
    logic                 core_reset;
    logic                 core_sample;
    logic                 core_power;
    logic                 core_clock_tick;
    logic [`NUM_PINS-1:0] pin_sel;
    logic                 ovc_sel;
    logic                 dcdc_sel;
    logic                 ref_sup;
    logic                 conv_done;
    int                   bad_count = 0;
    int                   checks_done = 0;
    int                   cyc = 0;          // Free cycle count for latency checks
    int                   t0 = 0;
    int                   t1 = 0;
    int                   n_rst = 0;
    int                   n_smp = 0;
    int                   n_done = 0;
    int                   n_tick = 0;       // Conversion clock ticks seen

    adc_control #(.CONV_TICKS(CT)) dut (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .core_result(core_result), .core_reset(core_reset), .core_sample(core_sample),
        .core_power(core_power), .core_clock_tick(core_clock_tick),
        .analog_pin_inputs_sel(pin_sel), .overcurrent_amp_output_sel(ovc_sel),
        .dcdc_divider_sel(dcdc_sel), .reference_from_supply(ref_sup), .conversion_done(conv_done));

    // 125 MHz clock
    always #4 clk = ~clk;

    // --------------------------------------------------------------------
    // Pulse monitor: sampled before the edge updates land, so no race
    // --------------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (core_sample === 1'b1) begin
            t0 = cyc;
            n_smp++;
        end
        if (conv_done === 1'b1) begin
            t1 = cyc;
            n_done++;
        end
        if (core_reset === 1'b1) begin
            n_rst++;
        end
        if (core_clock_tick === 1'b1) begin
            n_tick++;
        end
    end

    // --------------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (pready !== 1'b1) begin
            bad_count++;
            conclude();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, {24'h0, d}, rd, er);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, {24'h0, exp});
    endtask

    // Expected result byte for a given justification
    function automatic logic [7:0] fmt(input sample_t r, input logic j, input logic hi);
        if (!j) begin
            return hi ? r[11:4] : {r[3:0], 4'h0};
        end
        return hi ? {4'h0, r[11:8]} : r[7:0];
    endfunction

    // --------------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        logic        er;
        logic [2:0]  s;
        logic [3:0]  c;
        logic [1:0]  rf;
        logic [2:0]  dv;
        logic        en;
        logic        j;
        sample_t     r;
        int          k;
        int          n;
        int          m;
        void'($urandom(32'h7769));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        // Reset values and an unmapped address
        rdchk(`ADDR_RESULT_LOW, 8'h00);
        rdchk(`ADDR_RESULT_HIGH, 8'h00);
        rdchk(`ADDR_CONTROL_A, 8'h00);
        rdchk(`ADDR_CONTROL_B, 8'h00);
        apb(1'b0, 12'h010, 32'h0, rd, er);
        chk(32'(er), 32'h1);
        chk(rd, 32'h0);
        // Every source code, channel boundaries, reference codes
        for (int i = 0; i < 16; i++) begin
            s  = 3'(i);
            c  = (s == 3'h1 || s == 3'h2) ? 4'(6 + i % 10) : 4'(i);
            rf = 2'($urandom);
            dv = 3'($urandom);
            en = 1'($urandom);
            j  = 1'($urandom);
            wr(`ADDR_CONTROL_B, {s, rf, dv});
            wr(`ADDR_CONTROL_A, {2'b01, en, j, c});
            rdchk(`ADDR_CONTROL_B, {s, rf, dv});
            rdchk(`ADDR_CONTROL_A, {2'b00, en, j, c});
            chk(32'(pin_sel), (s != 3'h1 && s != 3'h2 && c <= 4'h5) ? 32'h1 << c : 32'h0);
            chk(32'(ovc_sel), 32'(s == 3'h1));
            chk(32'(dcdc_sel), 32'(s == 3'h2));
            chk(32'(pin_sel != 0), 32'(s != 3'h1 && s != 3'h2 && c <= 4'h5));
            chk(32'(ref_sup), 32'(rf == 2'h1));
            chk(32'(core_power), 32'(en));
        end
        // A conversion at every divider code
        for (int d = 0; d < 8; d++) begin
            j = 1'(d);
            r = 12'($urandom);
            core_result <= r;
            wr(`ADDR_CONTROL_B, {5'h00, 3'(d)});
            k = n_rst;
            n = n_done;
            m = n_tick;
            wr(`ADDR_CONTROL_A, {3'b101, j, 4'h0});
            wr(`ADDR_CONTROL_A, {3'b001, j, 4'h0});
            chk(32'(n_rst - k), 32'h1);
            if (d >= 3) begin
                rdchk(`ADDR_CONTROL_A, {3'b011, j, 4'h0});
            end
            k = 0;
            while (n_done == n && k < 3000) begin
                @(posedge clk);
                k++;
            end
            if (n_done == n) begin
                bad_count++;
                $display("Error at %0t: got %h expected %h", $time, 32'h0, 32'h1);
                conclude();
            end
            chk(32'((t1 - t0) >= (CT << d) - 1 && (t1 - t0) <= (CT << d) + 2), 32'h1);
            chk(32'(n_tick - m), 32'(CT));
            rdchk(`ADDR_RESULT_HIGH, fmt(r, j, 1'b1));
            rdchk(`ADDR_RESULT_LOW, fmt(r, j, 1'b0));
            rdchk(`ADDR_CONTROL_A, {3'b001, j, 4'h0});
        end
        // A start rise and fall with the converter off begin nothing
        k = n_smp;
        wr(`ADDR_CONTROL_A, 8'h20);
        wr(`ADDR_CONTROL_A, 8'h80);
        wr(`ADDR_CONTROL_A, 8'h00);
        repeat (10) @(posedge clk);
        chk(32'(n_smp - k), 32'h0);
        // Disabling clears both result bytes
        rdchk(`ADDR_RESULT_HIGH, 8'h00);
        rdchk(`ADDR_RESULT_LOW, 8'h00);
        // A new start rise aborts a long conversion
        wr(`ADDR_CONTROL_B, 8'h07);
        wr(`ADDR_CONTROL_A, 8'ha0);
        wr(`ADDR_CONTROL_A, 8'h20);
        wr(`ADDR_CONTROL_A, 8'ha0);
        rdchk(`ADDR_CONTROL_A, 8'ha0);
        wr(`ADDR_CONTROL_A, 8'h00);
        conclude();
    end
endmodule

`default_nettype wire
